// ==== verilog/bffm_top.v ====
// bias fault flag and mask register block with its two-wire register port
`timescale 1ns/1ps
`default_nettype none
`include "bffm_defines.vh"

module bffm_top #(
  parameter [6:0] DEV_ADDR   = `BFFM_DEV_ADDR,
  parameter       NUM_FAULTS = `BFFM_NUM_FAULTS
) (
  // clock, reset, enable
  input  wire                  mclk_i,
  input  wire                  reset_n_i,
  input  wire                  en_i,
  // two-wire register port
  input  wire                  scl_i,
  input  wire                  sda_i,
  output wire                  sda_o,
  output reg                   sda_oe_o,
  // fault detectors
  input  wire [NUM_FAULTS-1:0] fault_i,
  input  wire                  common_uv_i,
  input  wire                  common_ov_i,
  // fault output
  output wire                  fault_out_n_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  reg                   scl_q;
  reg                   scl_qq;
  reg                   sda_q;
  reg                   sda_qq;
  reg  [6:0]            state_q;
  reg  [3:0]            cnt_q;
  reg  [7:0]            sh_q;
  reg  [7:0]            ptr_q;
  reg                   rw_q;
  reg                   ptr_ph_q;
  reg                   ack_ok_q;
  reg  [NUM_FAULTS-1:0] mask1_q;
  reg                   com_uv_blk_q;
  reg                   com_ov_blk_q;
  reg                   latch_dis_q;
  reg                   flag_wr_q;
  reg  [NUM_FAULTS-1:0] flag_wdat_q;
  reg                   read_clear_q;
  reg  [7:0]            rdata;
  wire [NUM_FAULTS-1:0] ind;
  wire                  scl_rise;
  wire                  scl_fall;
  wire                  start_cond;
  wire                  stop_cond;

  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // line sampling and bus conditions
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_q  <= 1'b1;
      scl_qq <= 1'b1;
      sda_q  <= 1'b1;
      sda_qq <= 1'b1;
    end else if (en_i) begin
      scl_q  <= scl_i;
      scl_qq <= scl_q;
      sda_q  <= sda_i;
      sda_qq <= sda_q;
    end
  end

  assign scl_rise   = scl_q & ~scl_qq;
  assign scl_fall   = ~scl_q & scl_qq;
  assign start_cond = scl_q & scl_qq & sda_qq & ~sda_q;
  assign stop_cond  = scl_q & scl_qq & ~sda_qq & sda_q;

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always @* begin
    rdata = `BFFM_READ_ZERO;
    case (ptr_q)
      `BFFM_OFS_MASK1: begin
        rdata[NUM_FAULTS-1:0] = mask1_q;
      end
      `BFFM_OFS_MASK2: begin
        rdata[`BFFM_COM_UV_BIT] = com_uv_blk_q;
        rdata[`BFFM_COM_OV_BIT] = com_ov_blk_q;
      end
      `BFFM_OFS_FLAGS: begin
        rdata[NUM_FAULTS-1:0] = ind;
      end
      `BFFM_OFS_CTRL: begin
        rdata[`BFFM_LATCH_DIS_BIT] = latch_dis_q;
      end
      default: begin
        rdata = `BFFM_READ_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // link state machine and register writes
  // ----------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q      <= `BFFM_ST_IDLE;
      cnt_q        <= `BFFM_CNT_ZERO;
      sh_q         <= `BFFM_READ_ZERO;
      ptr_q        <= `BFFM_PTR_RST;
      rw_q         <= 1'b0;
      ptr_ph_q     <= 1'b0;
      ack_ok_q     <= 1'b0;
      sda_oe_o     <= 1'b0;
      mask1_q      <= `BFFM_MASK1_RST;
      com_uv_blk_q <= 1'b0;
      com_ov_blk_q <= 1'b0;
      latch_dis_q  <= `BFFM_LATCH_DIS_RST;
      flag_wr_q    <= 1'b0;
      flag_wdat_q  <= `BFFM_FLAGS_RST;
      read_clear_q <= 1'b0;
    end else if (en_i) begin
      flag_wr_q    <= 1'b0;
      read_clear_q <= 1'b0;
      if (start_cond) begin
        state_q  <= `BFFM_ST_ADDR;
        cnt_q    <= `BFFM_CNT_ZERO;
        sda_oe_o <= 1'b0;
      end else if (stop_cond) begin
        state_q  <= `BFFM_ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_q)
          `BFFM_ST_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          `BFFM_ST_ADDR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_q};
              cnt_q <= cnt_q + `BFFM_CNT_ONE;
            end else if (scl_fall && cnt_q == `BFFM_BITS_PER_BYTE) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rw_q     <= sh_q[0];
                sda_oe_o <= 1'b1;
                state_q  <= `BFFM_ST_ACK_A;
              end else begin
                state_q <= `BFFM_ST_IDLE;
              end
            end
          end
          `BFFM_ST_ACK_A: begin
            if (scl_fall) begin
              cnt_q <= `BFFM_CNT_ZERO;
              if (rw_q) begin
                sh_q         <= rdata;
                sda_oe_o     <= ~rdata[7];
                read_clear_q <= (ptr_q == `BFFM_OFS_FLAGS) & ~latch_dis_q;
                ptr_q        <= ptr_q + `BFFM_PTR_STEP;
                state_q      <= `BFFM_ST_RD;
              end else begin
                sda_oe_o <= 1'b0;
                ptr_ph_q <= 1'b1;
                state_q  <= `BFFM_ST_WR;
              end
            end
          end
          `BFFM_ST_WR: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda_q};
              cnt_q <= cnt_q + `BFFM_CNT_ONE;
            end else if (scl_fall && cnt_q == `BFFM_BITS_PER_BYTE) begin
              sda_oe_o <= 1'b1;
              state_q  <= `BFFM_ST_ACK_W;
              if (ptr_ph_q) begin
                ptr_q    <= sh_q;
                ptr_ph_q <= 1'b0;
              end else begin
                ptr_q <= ptr_q + `BFFM_PTR_STEP;
                case (ptr_q)
                  `BFFM_OFS_MASK1: begin
                    mask1_q <= sh_q[NUM_FAULTS-1:0];
                  end
                  `BFFM_OFS_MASK2: begin
                    com_uv_blk_q <= sh_q[`BFFM_COM_UV_BIT];
                    com_ov_blk_q <= sh_q[`BFFM_COM_OV_BIT];
                  end
                  `BFFM_OFS_FLAGS: begin
                    flag_wr_q   <= 1'b1;
                    flag_wdat_q <= sh_q[NUM_FAULTS-1:0];
                  end
                  `BFFM_OFS_CTRL: begin
                    latch_dis_q <= sh_q[`BFFM_LATCH_DIS_BIT];
                  end
                  default: begin
                    flag_wr_q <= 1'b0;
                  end
                endcase
              end
            end
          end
          `BFFM_ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              cnt_q    <= `BFFM_CNT_ZERO;
              state_q  <= `BFFM_ST_WR;
            end
          end
          `BFFM_ST_RD: begin
            if (scl_fall) begin
              cnt_q <= cnt_q + `BFFM_CNT_ONE;
              if (cnt_q == `BFFM_BITS_PER_BYTE - `BFFM_CNT_ONE) begin
                sda_oe_o <= 1'b0;
                state_q  <= `BFFM_ST_ACK_R;
              end else begin
                sh_q     <= {sh_q[6:0], 1'b0};
                sda_oe_o <= ~sh_q[6];
              end
            end
          end
          `BFFM_ST_ACK_R: begin
            if (scl_rise) begin
              ack_ok_q <= ~sda_q;
            end else if (scl_fall) begin
              cnt_q <= `BFFM_CNT_ZERO;
              if (ack_ok_q) begin
                sh_q         <= rdata;
                sda_oe_o     <= ~rdata[7];
                read_clear_q <= (ptr_q == `BFFM_OFS_FLAGS) & ~latch_dis_q;
                ptr_q        <= ptr_q + `BFFM_PTR_STEP;
                state_q      <= `BFFM_ST_RD;
              end else begin
                state_q <= `BFFM_ST_IDLE;
              end
            end
          end
          default: begin
            state_q  <= `BFFM_ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // fault indications and output
  // ----------------------------------------------------------------
  bffm_flags #(
    .NUM_FAULTS (NUM_FAULTS)
  ) u_flags (
    .mclk_i            (mclk_i),
    .reset_n_i         (reset_n_i),
    .en_i              (en_i),
    .fault_i           (fault_i),
    .common_uv_i       (common_uv_i),
    .common_ov_i       (common_ov_i),
    .latch_dis_i       (latch_dis_q),
    .mask_i            (mask1_q),
    .common_uv_block_i (com_uv_blk_q),
    .common_ov_block_i (com_ov_blk_q),
    .read_clear_i      (read_clear_q),
    .wr_i              (flag_wr_q),
    .wdata_i           (flag_wdat_q),
    .ind_o             (ind),
    .fault_out_n_o     (fault_out_n_o)
  );

endmodule // bffm_top
`default_nettype wire

// ==== common/bffm_defines.vh ====
// register map, field positions and reset values of the bias fault block
`ifndef BFFM_DEFINES_VH
`define BFFM_DEFINES_VH

// register offsets
`define BFFM_OFS_MASK1      8'h08
`define BFFM_OFS_MASK2      8'h09
`define BFFM_OFS_FLAGS      8'h0a
`define BFFM_OFS_CTRL       8'h0c

// field positions
`define BFFM_COM_UV_BIT     4
`define BFFM_COM_OV_BIT     3
`define BFFM_LATCH_DIS_BIT  0

// widths and reset values
`define BFFM_NUM_FAULTS     7
`define BFFM_FLAGS_RST      7'h00
`define BFFM_MASK1_RST      7'h00
`define BFFM_MASK2_RST      2'h0
`define BFFM_LATCH_DIS_RST  1'b0
`define BFFM_READ_ZERO      8'h00

// serial link constants; device address value is arbitrary
`define BFFM_DEV_ADDR       7'h2a
`define BFFM_BITS_PER_BYTE  4'h8
`define BFFM_CNT_ZERO       4'h0
`define BFFM_CNT_ONE        4'h1
`define BFFM_PTR_RST        8'h00
`define BFFM_PTR_STEP       8'h01

// one-hot link states
`define BFFM_ST_IDLE        7'h01
`define BFFM_ST_ADDR        7'h02
`define BFFM_ST_ACK_A       7'h04
`define BFFM_ST_WR          7'h08
`define BFFM_ST_ACK_W       7'h10
`define BFFM_ST_RD          7'h20
`define BFFM_ST_ACK_R       7'h40

`endif

// ==== verilog/bffm_flags.v ====
// per-fault indication cells, masking and fault output
`timescale 1ns/1ps
`default_nettype none
`include "bffm_defines.vh"

module bffm_flags #(
  parameter NUM_FAULTS = `BFFM_NUM_FAULTS
) (
  // clock and reset
  input  wire                  mclk_i,
  input  wire                  reset_n_i,
  input  wire                  en_i,
  // fault sources
  input  wire [NUM_FAULTS-1:0] fault_i,
  input  wire                  common_uv_i,
  input  wire                  common_ov_i,
  // settings
  input  wire                  latch_dis_i,
  input  wire [NUM_FAULTS-1:0] mask_i,
  input  wire                  common_uv_block_i,
  input  wire                  common_ov_block_i,
  // register accesses
  input  wire                  read_clear_i,
  input  wire                  wr_i,
  input  wire [NUM_FAULTS-1:0] wdata_i,
  // results
  output wire [NUM_FAULTS-1:0] ind_o,
  output reg                   fault_out_n_o
);

  reg  [NUM_FAULTS-1:0] flag_q;
  wire [NUM_FAULTS-1:0] clr;
  wire                  any_fault;

  // ----------------------------------------------------------------
  // indication cells
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_FAULTS; i = i + 1) begin : g_cell
      // read clear or written zero; a present fault outranks it
      assign clr[i] = read_clear_i | (wr_i & ~wdata_i[i]);
      always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          flag_q[i] <= 1'b0;
        end else if (en_i) begin
          if (latch_dis_i) begin
            flag_q[i] <= fault_i[i];
          end else begin
            flag_q[i] <= fault_i[i] | (flag_q[i] & ~clr[i]);
          end
        end
      end
    end
  endgenerate

  // live status or latched flag; zero means no fault seen
  assign ind_o = latch_dis_i ? fault_i : flag_q;

  // ----------------------------------------------------------------
  // fault output
  // ----------------------------------------------------------------
  assign any_fault = (|(ind_o & ~mask_i))
                   | (common_uv_i & ~common_uv_block_i)
                   | (common_ov_i & ~common_ov_block_i);

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_out_n_o <= 1'b1;
    end else if (en_i) begin
      fault_out_n_o <= ~any_fault;
    end
  end

endmodule // bffm_flags
`default_nettype wire

// ==== tb/bffm_monitor.sv ====
// port checker for the bias fault register block
`timescale 1ns/1ps
`default_nettype none
module bffm_monitor #(
  parameter NUM_FAULTS = 7
) (
  // clock and reset
  input wire logic                  mclk_i,
  input wire logic                  reset_n_i,
  input wire logic                  en_i,
  // register port
  input wire logic                  scl_i,
  input wire logic                  sda_i,
  input wire logic                  sda_o,
  input wire logic                  sda_oe_o,
  // faults
  input wire logic [NUM_FAULTS-1:0] fault_i,
  input wire logic                  common_uv_i,
  input wire logic                  common_ov_i,
  input wire logic                  fault_out_n_o
);
  logic [7:0]            scl_h_q;
  logic [4:0]            quiet_q;
  logic [NUM_FAULTS+1:0] fv;
  logic                  fell_w;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  assign fv = {common_uv_i, common_ov_i, fault_i};
  assign fell_w = |(scl_h_q[7:1] & ~scl_h_q[6:0]);
  // scl history and idle-bus count
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_h_q <= 8'hff;
      quiet_q <= 5'h00;
    end else begin
      scl_h_q <= {scl_h_q[6:0], scl_i};
      quiet_q <= (scl_i && sda_i) ? quiet_q + {4'h0, quiet_q != 5'h1f} : 5'h00;
    end
  end
  a_reset_out_idle:
    assert property ($rose(reset_n_i) |-> fault_out_n_o && !sda_oe_o)
    else $error("fault output or data drive wrong after reset");
  a_fall_has_fault:
    assert property ($fell(fault_out_n_o) && quiet_q == 5'h1f |-> |$past(fv, 1) || |$past(fv, 2))
    else $error("fault output fell with no fault present");
  a_change_needs_input:
    assert property ($changed(fault_out_n_o) && quiet_q == 5'h1f
      |-> $past(fv, 1) != $past(fv, 2) || $past(fv, 2) != $past(fv, 3))
    else $error("fault output moved on a quiet bus without input change");
  a_oe_moves_low:
    assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while clock line high");
  a_oe_rise_fall:
    assert property ($rose(sda_oe_o) |-> fell_w)
    else $error("data drive rose without a clock fall");
  a_oe_drop_fall:
    assert property ($fell(sda_oe_o) |-> fell_w)
    else $error("data drive dropped without a clock fall");
  a_oe_holds_bit:
    assert property ($rose(sda_oe_o) |-> sda_oe_o [*4])
    else $error("data drive not held for a bit");
  a_sda_open_drain:
    assert property (sda_o == 1'b0)
    else $error("data line output not low");
endmodule // bffm_monitor
bind bffm_top bffm_monitor #(.NUM_FAULTS(NUM_FAULTS)) u_mon (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .en_i(en_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .fault_i(fault_i), .common_uv_i(common_uv_i),
  .common_ov_i(common_ov_i), .fault_out_n_o(fault_out_n_o));
`default_nettype wire

// ==== tb/bffm_host.sv ====
// two-wire host model for the register port
`timescale 1ns/1ps
`default_nettype none
module bffm_host (
  // bus lines
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  logic nack_q;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    nack_q = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // also serves as repeated start
  task automatic start();
    sda_o <= 1'b1;
    hp(8);
    scl_o <= 1'b1;
    hp(8);
    sda_o <= 1'b0;
    hp(8);
    scl_o <= 1'b0;
    hp(2);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    hp(6);
    scl_o <= 1'b1;
    hp(8);
    sda_o <= 1'b1;
    hp(8);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    hp(6);
    scl_o <= 1'b1;
    hp(8);
    r = sda_i;
    scl_o <= 1'b0;
    hp(2);
  endtask
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(last, a);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    xfer({dev, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop();
    nack_q = a0 | a1 | a2;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start();
    xfer({dev, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    start();
    xfer({dev, 1'b1}, 1'b1, r, a2);
    xfer(8'hff, 1'b1, d, a3);
    stop();
    nack_q = a0 | a1 | a2;
  endtask
endmodule // bffm_host
`default_nettype wire

// ==== tb/bias_fault_flag_and_mask_logic_tb.sv ====
// self-checking bench for the bias fault register block
`timescale 1ns/1ps
`default_nettype none
module bias_fault_flag_and_mask_logic_tb;
  localparam logic [6:0] DEV = 7'h2a;
  logic       mclk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       en = 1'b1;
  logic [6:0] fault_i = 7'h00;
  logic       cuv = 1'b0;
  logic       cov = 1'b0;
  logic [7:0] v, m, d;
  logic [7:0] ofs [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  wire        scl, sda_h, sda_oe, fo_n, sda;
  int         n_fail = 0;
  int         n_checks = 0;
  int         seed = 32'hd31b;
  assign sda = sda_h & ~sda_oe;
  always #4 mclk_i = ~mclk_i;
  bffm_top #(.DEV_ADDR(DEV)) dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .en_i(en),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .fault_i(fault_i),
    .common_uv_i(cuv), .common_ov_i(cov), .fault_out_n_o(fo_n));
  bffm_host host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] p, input logic [7:0] e);
    host.rd(DEV, p, d);
    chk(nm, e, d);
  endtask
  function automatic logic [7:0] exp_out(input logic [6:0] ind, input logic [6:0] mk,
                                         input logic [7:0] m2, input logic u, input logic o);
    return {7'h0, !(|(ind & ~mk) | u & !m2[4] | o & !m2[3])};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400us;
    n_fail++;
    final_report();
  end
  initial begin
    cyc(12);
    reset_n_i <= 1'b1;
    cyc(4);
    foreach (ofs[i]) rd_chk("reset reg", ofs[i], 8'h00);
    $display("reset values done");
    v = $random(seed);
    host.wr(DEV, 8'h08, v);
    chk("ack", 8'h00, {7'h0, host.nack_q});
    rd_chk("mask rw", 8'h08, v & 8'h7f);
    v = $random(seed);
    host.wr(DEV, 8'h09, v);
    rd_chk("block rw", 8'h09, v & 8'h18);
    host.wr(DEV, 8'h08, 8'h00);
    host.wr(DEV, 8'h09, 8'h00);
    host.wr(DEV ^ 7'h01, 8'h08, 8'h7f);
    chk("addr nack", 8'h01, {7'h0, host.nack_q});
    rd_chk("mask kept", 8'h08, 8'h00);
    $display("register access done");
    repeat (4) begin
      cyc(32);
      v = $random(seed) & 8'h7f;
      fault_i <= v[6:0];
      cyc(3);
      fault_i <= 7'h00;
      cyc(3);
      chk("out latched", exp_out(v[6:0], 7'h0, 8'h0, 1'b0, 1'b0), {7'h0, fo_n});
      rd_chk("latched", 8'h0a, v);
      rd_chk("read clear", 8'h0a, 8'h00);
      chk("out cleared", 8'h01, {7'h0, fo_n});
    end
    fault_i <= 7'h41;
    cyc(3);
    rd_chk("held", 8'h0a, 8'h41);
    rd_chk("reassert", 8'h0a, 8'h41);
    fault_i <= 7'h00;
    cyc(3);
    host.wr(DEV, 8'h0a, 8'h7e);
    rd_chk("write zero", 8'h0a, 8'h40);
    m = $random(seed) & 8'h7f;
    host.wr(DEV, 8'h08, m);
    v = $random(seed) & 8'h7f;
    fault_i <= v[6:0];
    cyc(3);
    fault_i <= 7'h00;
    cyc(3);
    chk("out masked", exp_out(v[6:0], m[6:0], 8'h0, 1'b0, 1'b0), {7'h0, fo_n});
    rd_chk("flags masked", 8'h0a, v);
    host.wr(DEV, 8'h08, 8'h00);
    // enable low: a fault pulse must leave no trace
    en <= 1'b0;
    fault_i <= 7'h7f;
    cyc(4);
    fault_i <= 7'h00;
    cyc(2);
    en <= 1'b1;
    cyc(4);
    chk("out frozen", 8'h01, {7'h0, fo_n});
    rd_chk("frozen flags", 8'h0a, 8'h00);
    $display("latched mode done");
    host.wr(DEV, 8'h0c, 8'h01);
    v = $random(seed) & 8'h7f;
    fault_i <= v[6:0];
    rd_chk("live", 8'h0a, v);
    chk("out live", exp_out(v[6:0], 7'h0, 8'h0, 1'b0, 1'b0), {7'h0, fo_n});
    fault_i <= 7'h00;
    rd_chk("live gone", 8'h0a, 8'h00);
    chk("out free", 8'h01, {7'h0, fo_n});
    for (int k = 1; k < 8; k++) begin
      cuv <= k[0];
      cov <= k[1];
      m = $random(seed) & 8'h18;
      host.wr(DEV, 8'h09, m);
      cyc(2);
      chk("out common", exp_out(7'h0, 7'h0, m, k[0], k[1]), {7'h0, fo_n});
    end
    $display("live and common done");
    final_report();
  end
endmodule // bias_fault_flag_and_mask_logic_tb
`default_nettype wire
